// ---- design/eeprom_controller.sv ----
`timescale 1ns/1ns
module eeprom_controller #(
  parameter int QUARTER_CYCLES = eeprom_pkg::SCL_QUARTER_CYCLES
) (
  input  wire logic                clk,        // System clock.
  input  wire logic                rst,        // Asynchronous reset.
  two_wire_if.controller           bus,        // Two-wire link.
  input  wire logic                cmd_valid,  // Command offered.
  output logic                     cmd_ready,  // Controller idle, takes command.
  input  wire eeprom_pkg::cmd_type cmd_kind,   // Write, poll or recover.
  input  wire logic [2:0]          cmd_sel,    // Target select bits.
  input  wire logic [15:0]         cmd_addr,   // Word address, high byte first.
  input  wire logic                wr_valid,   // Data byte offered.
  output logic                     wr_ready,   // Data byte taken.
  input  wire logic [7:0]          wr_data,    // Data byte.
  input  wire logic                wr_last,    // Final byte of the write.
  output logic                     done,       // Command finished, one pulse.
  output logic                     nack        // Last command saw no acknowledge.
);

  if (QUARTER_CYCLES < 2 || QUARTER_CYCLES > 65535) begin : g_bad_quarter
    $error("QUARTER_CYCLES out of range.");
  end

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_LOAD,
    H_BIT,
    H_STOP,
    H_REC
  } host_state_type;

  host_state_type      state_reg;
  logic [15:0]         div_reg;
  logic                sda_s1_reg;
  logic                sda_s2_reg;
  logic [1:0]          q_reg;
  logic [3:0]          bit_cnt_reg;
  logic [1:0]          idx_reg;
  logic [7:0]          shift_reg;
  logic                scl_reg;
  logic                oe_reg;
  eeprom_pkg::cmd_type kind_reg;
  logic [2:0]          sel_reg;
  logic [15:0]         addr_reg;
  logic                last_reg;
  logic [3:0]          rec_cnt_reg;
  logic                rec_done_reg;
  logic                done_reg;
  logic                nack_reg;
  logic [7:0]          next_byte;

  // Quarter-period tick of the serial clock divider.
  wire tick     = div_reg == 16'(QUARTER_CYCLES - 1);
  wire ack_slot = bit_cnt_reg == eeprom_pkg::ACK_SLOT;
  wire end_xfer = nack_reg || kind_reg == eeprom_pkg::CMD_POLL || (idx_reg == 2'd3 && last_reg);

  // Byte order on the wire: device word, address high, address low, data.
  always_comb begin
    case (idx_reg)
      2'd0:    next_byte = {eeprom_pkg::PREAMBLE, sel_reg, 1'b0};
      2'd1:    next_byte = addr_reg[15:8];
      2'd2:    next_byte = addr_reg[7:0];
      default: next_byte = wr_data;
    endcase
  end

  // The data line comes from another domain and passes two flip-flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      div_reg    <= 16'h0;
    end else begin
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
      div_reg    <= tick ? 16'h0 : div_reg + 16'h1;
    end
  end

  // Sequencer; each bit takes four quarters and the data line moves with the clock low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= H_IDLE;
      q_reg        <= 2'd0;
      bit_cnt_reg  <= 4'h0;
      idx_reg      <= 2'd0;
      shift_reg    <= 8'h00;
      scl_reg      <= 1'b1;
      oe_reg       <= 1'b0;
      kind_reg     <= eeprom_pkg::CMD_WRITE;
      sel_reg      <= 3'h0;
      addr_reg     <= 16'h0;
      last_reg     <= 1'b0;
      rec_cnt_reg  <= 4'h0;
      rec_done_reg <= 1'b0;
      done_reg     <= 1'b0;
      nack_reg     <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            kind_reg     <= cmd_kind;
            sel_reg      <= cmd_sel;
            addr_reg     <= cmd_addr;
            nack_reg     <= 1'b0;
            idx_reg      <= 2'd0;
            q_reg        <= 2'd0;
            rec_cnt_reg  <= 4'h0;
            rec_done_reg <= 1'b0;
            state_reg    <= (cmd_kind == eeprom_pkg::CMD_RECOVER) ? H_REC : H_START;
          end
        end
        H_START: begin
          if (tick) begin
            q_reg <= q_reg + 2'd1;
            if (q_reg == 2'd1) begin
              oe_reg <= 1'b1;  // Data falls while the clock is high.
            end
            if (q_reg == 2'd2) begin
              scl_reg <= 1'b0;
            end
            if (q_reg == 2'd3) begin
              state_reg <= rec_done_reg ? H_STOP : H_LOAD;
            end
          end
        end
        H_LOAD: begin
          // Data bytes wait here with the clock held low until the source offers one.
          if (idx_reg != 2'd3 || wr_valid) begin
            shift_reg   <= next_byte;
            bit_cnt_reg <= 4'h0;
            q_reg       <= 2'd0;
            state_reg   <= H_BIT;
            if (idx_reg == 2'd3) begin
              last_reg <= wr_last;
            end
          end
        end
        H_BIT: begin
          if (tick) begin
            q_reg <= q_reg + 2'd1;
            case (q_reg)
              2'd0:    oe_reg  <= ack_slot ? 1'b0 : !shift_reg[7];
              2'd1:    scl_reg <= 1'b1;
              2'd2: begin
                if (ack_slot) begin
                  nack_reg <= sda_s2_reg;
                end else begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                end
              end
              default: begin
                scl_reg <= 1'b0;
                if (!ack_slot) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else if (end_xfer) begin
                  state_reg <= H_STOP;
                end else begin
                  idx_reg   <= (idx_reg == 2'd3) ? 2'd3 : idx_reg + 2'd1;
                  state_reg <= H_LOAD;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            q_reg <= q_reg + 2'd1;
            case (q_reg)
              2'd0:    oe_reg  <= 1'b1;
              2'd1:    scl_reg <= 1'b1;
              2'd2:    oe_reg  <= 1'b0;  // Data rises while the clock is high.
              default: begin
                done_reg  <= 1'b1;
                state_reg <= H_IDLE;
              end
            endcase
          end
        end
        H_REC: begin
          // Clock with the data line released until it reads high, nine times at most.
          if (tick) begin
            q_reg <= q_reg + 2'd1;
            case (q_reg)
              2'd0: begin
                scl_reg <= 1'b0;
                oe_reg  <= 1'b0;
              end
              2'd1:    scl_reg <= 1'b1;
              2'd2:    rec_done_reg <= sda_s2_reg
                                       || rec_cnt_reg == 4'(eeprom_pkg::RECOVER_CLOCKS - 1);
              default: begin
                rec_cnt_reg <= rec_cnt_reg + 4'h1;
                if (rec_done_reg) begin
                  nack_reg  <= !sda_s2_reg;
                  state_reg <= H_START;
                end
              end
            endcase
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Only the enable of the data line is driven; its level is always low.
  assign bus.scl        = scl_reg;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = oe_reg;
  assign cmd_ready      = state_reg == H_IDLE;
  assign wr_ready       = state_reg == H_LOAD && idx_reg == 2'd3;
  assign done           = done_reg;
  assign nack           = nack_reg;

endmodule : eeprom_controller

// ---- design/eeprom_target.sv ----
`timescale 1ns/1ns
// Overview of operation
// - Write-protect high blocks every array update.
// - Small variant: 128 pages, 12-bit address.
// - Large variant: 256 pages, 13-bit address.
// - Data changes only while clock low.
// - Data falling with clock high is start.
// - Data rising with clock high is stop.
// - Sample on clock rise, drive after fall.
// - Acknowledge each byte low on ninth clock.
// - Standby after reset and after stop.
// - Controller recovers with up to nine clocks.
// - Device word starts with fixed preamble.
// - Three select bits must match pins.
// - Lowest device word bit selects direction.
// - Mismatch gives no acknowledge, returns standby.
// - Byte write: two address bytes, data, stop.
// - Write cycle after stop ignores all inputs.
// - Write cycle ends within five milliseconds.
// - Page write takes up to 31 more bytes.
// - Only low five address bits advance, wrapping.
// - Partial pages program only received bytes.
// - Poll acknowledged only after write completes.
// - Data line only pulled low or released.
module eeprom_target #(
  parameter int ADDR_BITS          = eeprom_pkg::ADDR_BITS_LARGE,
  parameter int WRITE_CYCLE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYCLES
) (
  input  wire logic                 link_clk,       // Device clock.
  input  wire logic                 rst,            // Asynchronous reset.
  two_wire_if.target                bus,            // Two-wire link.
  input  wire logic                 select_pin_0,   // Hard-wired select bit 0.
  input  wire logic                 select_pin_1,   // Hard-wired select bit 1.
  input  wire logic                 select_pin_2,   // Hard-wired select bit 2.
  input  wire logic                 write_protect,  // High blocks programming.
  input  wire logic [ADDR_BITS-1:0] mem_rd_addr,    // Array inspection address.
  output logic      [7:0]           mem_rd_data,    // Array byte, one cycle later.
  output logic                      standby,        // Idle and not programming.
  output logic                      write_busy      // Write cycle in progress.
);

  localparam int COL_BITS  = eeprom_pkg::COL_BITS;
  localparam int PAGE_BITS = ADDR_BITS - COL_BITS;
  localparam int FLT       = eeprom_pkg::FILTER_LEN;

  // Only the two documented array sizes are served.
  if (ADDR_BITS != eeprom_pkg::ADDR_BITS_SMALL &&
      ADDR_BITS != eeprom_pkg::ADDR_BITS_LARGE) begin : g_bad_addr
    $error("ADDR_BITS must be 12 or 13.");
  end
  if (WRITE_CYCLE_CYCLES < 2 * eeprom_pkg::PAGE_BYTES) begin : g_bad_cycle
    $error("WRITE_CYCLE_CYCLES too small for a page sweep.");
  end

  typedef enum logic [2:0] {
    D_IDLE,
    D_DEV,
    D_ADDR_HI,
    D_ADDR_LO,
    D_DATA,
    D_IGNORE
  } dev_state_type;

  dev_state_type        state_reg;
  dev_state_type        state_next;
  logic [5:0]           sync1_reg;
  logic [5:0]           sync2_reg;
  logic [1:0]           line_f;
  logic [1:0]           prev_reg;
  logic [3:0]           bit_cnt_reg;
  logic [7:0]           shift_reg;
  logic                 ack_phase_reg;
  logic                 sda_oe_reg;
  logic [7:0]           addr_hi_reg;
  logic [PAGE_BITS-1:0] page_reg;
  logic [COL_BITS-1:0]  col_reg;
  logic [31:0]          valid_reg;
  logic                 busy_reg;
  logic [5:0]           prog_idx_reg;
  logic [31:0]          timer_reg;
  logic [7:0]           page_buf [eeprom_pkg::PAGE_BYTES];
  logic [7:0]           mem [2**ADDR_BITS];
  logic [7:0]           mem_rd_data_reg;

  // Pins from the outside pass two flip-flops; only the second is read.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= eeprom_pkg::PIN_SYNC_RESET;
      sync2_reg <= eeprom_pkg::PIN_SYNC_RESET;
    end else begin
      sync1_reg <= {write_protect, select_pin_2, select_pin_1, select_pin_0, bus.sda, bus.scl};
      sync2_reg <= sync1_reg;
    end
  end

  // A line level is accepted only after FLT equal samples, so short spikes are dropped.
  for (genvar g = 0; g < 2; g++) begin : g_filter
    logic [FLT-1:0] hist_reg;
    logic           filt_reg;
    always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
        hist_reg <= '1;
        filt_reg <= 1'b1;
      end else begin
        hist_reg <= {hist_reg[FLT-2:0], sync2_reg[g]};
        if (&hist_reg) begin
          filt_reg <= 1'b1;
        end else if (~|hist_reg) begin
          filt_reg <= 1'b0;
        end
      end
    end
    assign line_f[g] = filt_reg;
  end

  // Edge and condition decoding on the filtered lines; bit 0 is clock, bit 1 is data.
  wire       scl_rise   = line_f[0] & ~prev_reg[0];
  wire       scl_fall   = ~line_f[0] & prev_reg[0];
  wire       start_seen = prev_reg[0] & line_f[0] & prev_reg[1] & ~line_f[1];
  wire       stop_seen  = prev_reg[0] & line_f[0] & ~prev_reg[1] & line_f[1];
  wire       wp_s       = sync2_reg[5];
  wire [2:0] sel_s      = sync2_reg[4:2];
  wire       engine_on  = !busy_reg && !start_seen && !stop_seen && state_reg != D_IDLE;

  // The device word needs the preamble and the select pins to match.
  wire dev_match = shift_reg[7:eeprom_pkg::PREAMBLE_LSB] == eeprom_pkg::PREAMBLE
                   && shift_reg[eeprom_pkg::SEL_LSB +: 3] == sel_s;
  wire byte_done = engine_on && scl_fall && bit_cnt_reg == eeprom_pkg::ACK_SLOT
                   && !ack_phase_reg;
  wire ack_now   = (state_reg == D_DEV) ? dev_match : (state_reg != D_IGNORE);

  // Upper received address bits beyond the variant width are dropped.
  wire [15:0]          word_addr = {addr_hi_reg, shift_reg};
  wire [ADDR_BITS-1:0] cur_addr  = word_addr[ADDR_BITS-1:0];

  // Programming sweeps the page buffer, writing only bytes that arrived.
  wire [COL_BITS-1:0] prog_col = prog_idx_reg[COL_BITS-1:0];
  wire prog_we   = busy_reg && !prog_idx_reg[COL_BITS] && valid_reg[prog_col];
  wire timer_end = timer_reg == 32'(WRITE_CYCLE_CYCLES - 1);
  wire commit    = stop_seen && !busy_reg && state_reg == D_DATA && |valid_reg && !wp_s;

  // Next state at the end of each received byte.
  always_comb begin
    case (state_reg)
      D_DEV:     state_next = !dev_match ? D_IDLE
                            : (shift_reg[eeprom_pkg::RW_BIT] ? D_IGNORE : D_ADDR_HI);
      D_ADDR_HI: state_next = D_ADDR_LO;
      D_ADDR_LO: state_next = D_DATA;
      D_DATA:    state_next = D_DATA;
      D_IGNORE:  state_next = D_IGNORE;
      default:   state_next = D_IDLE;
    endcase
  end

  // Write cycle: inputs are ignored until the timer ends, so polls get no acknowledge.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      prog_idx_reg <= 6'h00;
      timer_reg    <= 32'h0;
    end else if (commit) begin
      busy_reg     <= 1'b1;
      prog_idx_reg <= 6'h00;
      timer_reg    <= 32'h0;
    end else if (busy_reg) begin
      prog_idx_reg <= prog_idx_reg + {5'h00, !prog_idx_reg[COL_BITS]};
      timer_reg    <= timer_reg + 32'h1;
      if (timer_end) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Bit engine: sample on the rise, change the data line only after a fall.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= D_IDLE;
      prev_reg      <= 2'h3;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ack_phase_reg <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else begin
      prev_reg <= line_f;
      if (busy_reg || stop_seen) begin
        state_reg  <= D_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (start_seen) begin
        state_reg     <= D_DEV;
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        sda_oe_reg    <= 1'b0;
      end else if (engine_on) begin
        if (scl_rise && bit_cnt_reg < eeprom_pkg::ACK_SLOT) begin
          shift_reg   <= {shift_reg[6:0], line_f[1]};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (scl_fall && ack_phase_reg) begin
          sda_oe_reg    <= 1'b0;  // Release at the end of the ninth clock.
          ack_phase_reg <= 1'b0;
          bit_cnt_reg   <= 4'h0;
        end else if (byte_done) begin
          sda_oe_reg    <= ack_now;
          ack_phase_reg <= 1'b1;
          state_reg     <= state_next;
        end
      end
    end
  end

  // Address capture and page-local column advance.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      addr_hi_reg <= 8'h00;
      page_reg    <= '0;
      col_reg     <= '0;
      valid_reg   <= 32'h0;
    end else if (start_seen && !busy_reg) begin
      valid_reg <= 32'h0;  // A new transfer starts with an empty page buffer.
    end else if (byte_done) begin
      if (state_reg == D_ADDR_HI) begin
        addr_hi_reg <= shift_reg;
      end
      if (state_reg == D_ADDR_LO) begin
        page_reg <= cur_addr[ADDR_BITS-1:COL_BITS];
        col_reg  <= cur_addr[COL_BITS-1:0];
      end
      if (state_reg == D_DATA) begin
        col_reg <= col_reg + 5'h01;  // Carry never reaches the page bits.
        if (!wp_s) begin
          valid_reg[col_reg] <= 1'b1;
        end
      end
    end
  end

  // Page buffer: a byte past the 32nd overwrites the same column.
  always_ff @(posedge link_clk) begin
    if (byte_done && state_reg == D_DATA) begin
      page_buf[col_reg] <= shift_reg;
    end
  end

  // Array update only happens from the sweep, which protection already blocked.
  always_ff @(posedge link_clk) begin
    if (prog_we) begin
      mem[{page_reg, prog_col}] <= page_buf[prog_col];
    end
  end

  // Inspection read of the array for the user side.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      mem_rd_data_reg <= 8'h00;
    end else begin
      mem_rd_data_reg <= mem[mem_rd_addr];
    end
  end

  // The data line is open drain: level fixed low, only the enable moves.
  assign bus.tgt_sda_o  = 1'b0;
  assign bus.tgt_sda_oe = sda_oe_reg;
  assign mem_rd_data    = mem_rd_data_reg;
  assign standby        = state_reg == D_IDLE && !busy_reg;
  assign write_busy     = busy_reg;

endmodule : eeprom_target

// ---- include/eeprom_pkg.sv ----
package eeprom_pkg;

  // Device address word layout.
  localparam logic [3:0] PREAMBLE = 4'ha;  // Fixed family code in the top nibble.
  localparam int PREAMBLE_LSB = 4;
  localparam int SEL_LSB      = 1;
  localparam int RW_BIT       = 0;

  // Page geometry: only the column bits advance during a page write.
  localparam int COL_BITS   = 5;
  localparam int PAGE_BYTES = 32;
  localparam int ADDR_BITS_SMALL = 12;
  localparam int ADDR_BITS_LARGE = 13;

  // Bit position of the acknowledge within one transfer, and the most recovery clocks.
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int RECOVER_CLOCKS = 9;

  // Self-timed write cycle, a longest time, so the count rounds down.
  localparam int WRITE_CYCLE_TIME_NS = 5000000;
  localparam int LINK_CLK_PERIOD_NS  = 15;
  localparam int WRITE_CYCLE_CYCLES  = WRITE_CYCLE_TIME_NS / LINK_CLK_PERIOD_NS;

  // Controller serial clock, a least period, so the quarter count rounds up.
  localparam int SCL_PERIOD_NS      = 2500;
  localparam int CLK_PERIOD_NS      = 8;
  localparam int SCL_QUARTER_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                      / (4 * CLK_PERIOD_NS);

  // Length of the input glitch filter in link clock samples.
  localparam int FILTER_LEN = 3;

  // Reset value of the synchronised pins: lines idle high.
  localparam logic [5:0] PIN_SYNC_RESET = 6'h03;

  // Commands that the controller end carries out.
  typedef enum logic [1:0] {
    CMD_WRITE,
    CMD_POLL,
    CMD_RECOVER
  } cmd_type;

endpackage : eeprom_pkg

// ---- include/two_wire_if.sv ----
`timescale 1ns/1ns
interface two_wire_if;
  logic scl;         // Serial clock, driven by the controller.
  logic ctl_sda_o;   // Controller data output level, always low.
  logic ctl_sda_oe;  // Controller pulls the data line.
  logic tgt_sda_o;   // Target data output level, always low.
  logic tgt_sda_oe;  // Target pulls the data line.
  logic sda;         // Resolved data line with its pull-up.

  // Wired-AND of both open-drain drivers; released means high.
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (tgt_sda_oe && !tgt_sda_o));

  modport controller (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
endinterface : two_wire_if

// ---- tb/link_properties.sv ----
`timescale 1ns/1ns
// Watches the wire between both ends; each end's pull is seen apart from the resolved line.
module link_properties (
  input wire logic clk,         // System clock.
  input wire logic link_clk,    // Target clock.
  input wire logic rst,         // Shared reset.
  input wire logic scl,         // Serial clock.
  input wire logic sda,         // Resolved data.
  input wire logic ctl_sda_o,   // Controller level.
  input wire logic ctl_sda_oe,  // Controller pull.
  input wire logic tgt_sda_o,   // Target level.
  input wire logic tgt_sda_oe   // Target pull.
);
  // Start and stop are data edges while the clock stays high.
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  tgt_open_drain_a: assert property (@(posedge link_clk) disable iff (rst) !tgt_sda_o)
    else $error("target drove data high");
  ctl_open_drain_a: assert property (@(posedge clk) disable iff (rst) !ctl_sda_o)
    else $error("controller drove data high");
  tgt_changes_low_a: assert property (@(posedge link_clk) disable iff (rst)
    $changed(tgt_sda_oe) |-> !scl) else $error("target data moved with clock high");
  ack_width_a: assert property (@(posedge link_clk) disable iff (rst)
    $rose(tgt_sda_oe) |-> tgt_sda_oe [*8] ##[1:40] !tgt_sda_oe) else $error("bad ack width");
  ack_alone_a: assert property (@(posedge link_clk) disable iff (rst)
    tgt_sda_oe && scl |-> !ctl_sda_oe) else $error("controller pulled during ack");
  start_source_a: assert property (@(posedge clk) disable iff (rst)
    start_s |-> ctl_sda_oe) else $error("start not made by controller");
  start_clock_a: assert property (@(posedge clk) disable iff (rst)
    start_s |-> ##[1:20] !scl) else $error("no clocking after start");
  stop_idle_a: assert property (@(posedge clk) disable iff (rst)
    stop_s |-> scl [*8]) else $error("clock moved right after stop");
endmodule : link_properties

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  localparam eeprom_pkg::cmd_type WR = eeprom_pkg::CMD_WRITE, PL = eeprom_pkg::CMD_POLL;
  // One command, its expected nack and one array byte to inspect afterwards.
  typedef struct packed {
    eeprom_pkg::cmd_type kind; logic [2:0] sel; logic [15:0] addr; logic [5:0] n;
    logic [7:0] d0; logic wp; logic nack; logic [12:0] chk; logic [7:0] exp;
  } row_type;
  logic clk = 1'b0, link_clk = 1'b0, rst = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0;
  logic wr_last = 1'b0, write_protect = 1'b0, cmd_ready, wr_ready, done, nack, standby;
  logic write_busy;
  eeprom_pkg::cmd_type cmd_kind = WR;
  logic [2:0] cmd_sel = 3'h0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] wr_data = 8'h00, mem_rd_data;
  logic [12:0] mem_rd_addr = 13'h0000;
  logic [2:0] select_pins = 3'h5;
  int mismatches = 0, checks = 0, cycles = 0;
  row_type rows [7];
  two_wire_if link ();
  // Short counts keep the run brief; scl low still outlasts the target's input filter.
  eeprom_controller #(.QUARTER_CYCLES(8)) u_eeprom_controller (.clk(clk), .rst(rst),
    .bus(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .wr_last(wr_last), .done(done), .nack(nack));
  eeprom_target #(.ADDR_BITS(13), .WRITE_CYCLE_CYCLES(400)) u_eeprom_target (
    .link_clk(link_clk), .rst(rst), .bus(link), .select_pin_0(select_pins[0]),
    .select_pin_1(select_pins[1]), .select_pin_2(select_pins[2]),
    .write_protect(write_protect), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .standby(standby), .write_busy(write_busy));
  link_properties u_link_properties (.clk(clk), .link_clk(link_clk), .rst(rst),
    .scl(link.scl), .sda(link.sda), .ctl_sda_o(link.ctl_sda_o),
    .ctl_sda_oe(link.ctl_sda_oe), .tgt_sda_o(link.tgt_sda_o), .tgt_sda_oe(link.tgt_sda_oe));
  // The link clock runs at 15 ns against 8 ns, so the phases keep drifting.
  always #4 clk = ~clk;
  always begin
    #8 link_clk = 1'b1;
    #7 link_clk = 1'b0;
  end
  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask : cmp8
  task automatic cmp1(input string what, input logic e, input logic s);
    cmp8(what, {7'h00, e}, {7'h00, s});
  endtask : cmp1
  // Bytes are offered ahead and advance only at an edge that saw wr_ready high.
  task automatic run(input row_type r);
    int i;
    int t;
    i = 0;
    t = 0;
    write_protect <= r.wp;
    cmd_kind <= r.kind;
    cmd_sel <= r.sel;
    cmd_addr <= r.addr;
    cmd_valid <= 1'b1;
    wr_valid <= (r.n != 6'h00);
    wr_data <= r.d0;
    wr_last <= (r.n == 6'h01);
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && t < 20000) begin
      @(posedge clk);
      t++;
      if (wr_ready === 1'b1 && wr_valid) begin
        i++;
        wr_data <= r.d0 + 8'(i);
        wr_last <= (i + 1 == int'(r.n));
        wr_valid <= (i < int'(r.n));
      end
    end
    cmp1("done", 1'b1, done);
    // One edge passes so that the next call never reassigns wr_valid in this time step.
    wr_valid <= 1'b0;
    @(posedge clk);
  endtask : run
  task automatic settle();
    repeat (20) @(posedge clk);
    for (int k = 0; k < 2000 && standby !== 1'b1; k++) @(posedge clk);
    cmp1("standby", 1'b1, standby);
  endtask : settle
  task automatic peek(input logic [12:0] a, input logic [7:0] e);
    @(posedge link_clk);
    mem_rd_addr <= a;
    repeat (3) @(posedge link_clk);
    cmp8("mem_rd_data", e, mem_rd_data);
  endtask : peek
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    row_type pr;
    // A real rising edge of reset at time zero clears both ends before any clock edge.
    rst <= 1'b1;
    pr = '{PL, 3'h5, 16'h0000, 6'h00, 8'h00, 1'b0, 1'b0, 13'h0000, 8'h00};
    rows[0] = '{WR, 3'h5, 16'h0040, 6'h01, 8'h11, 1'b0, 1'b0, 13'h0040, 8'h11};
    rows[1] = '{WR, 3'h2, 16'h0040, 6'h01, 8'h22, 1'b0, 1'b1, 13'h0040, 8'h11};
    rows[2] = '{WR, 3'h5, 16'h005e, 6'h04, 8'h30, 1'b0, 1'b0, 13'h0041, 8'h33};
    rows[3] = '{WR, 3'h5, 16'h0041, 6'h01, 8'h44, 1'b1, 1'b0, 13'h0041, 8'h33};
    rows[4] = '{WR, 3'h5, 16'he061, 6'h01, 8'h55, 1'b0, 1'b0, 13'h0061, 8'h55};
    rows[5] = '{PL, 3'h5, 16'h0000, 6'h00, 8'h00, 1'b0, 1'b0, 13'h0040, 8'h32};
    rows[6] = '{eeprom_pkg::CMD_RECOVER, 3'h5, 16'h0000, 6'h00, 8'h00, 1'b0, 1'b0,
                13'h005f, 8'h31};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    cmp1("standby", 1'b1, standby);
    foreach (rows[i]) begin
      run(rows[i]);
      cmp1("nack", rows[i].nack, nack);
      settle();
      peek(rows[i].chk, rows[i].exp);
    end
    // Overrun a page by one byte, then poll at once while the write cycle runs.
    run('{WR, 3'h5, 16'h0100, 6'h21, 8'h60, 1'b0, 1'b0, 13'h0000, 8'h00});
    run(pr);
    cmp1("nack", 1'b1, nack);
    cmp1("write_busy", 1'b1, write_busy);
    for (int k = 0; k < 20 && nack !== 1'b0; k++) run(pr);
    cmp1("nack", 1'b0, nack);
    settle();
    peek(13'h0100, 8'h80);
    peek(13'h0101, 8'h61);
    // A second reset in the middle of a write must leave both ends idle.
    @(posedge clk);
    cmd_kind <= WR;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (200) @(posedge clk);
    cmp1("standby", 1'b0, standby);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp1("standby", 1'b1, standby);
    cmp1("write_busy", 1'b0, write_busy);
    cmp1("cmd_ready", 1'b1, cmd_ready);
    cmp1("wr_ready", 1'b0, wr_ready);
    cmp1("nack", 1'b0, nack);
    repeat (10) @(posedge clk);
    run(pr);
    cmp1("nack", 1'b0, nack);
    conclude();
  end
endmodule : testbench
